/* File: hw/gdio_pkg.sv */
// Package of register offsets, field positions and reset values for the I/O port
package gdio_pkg;
    // ==========================================
    // Register map (byte addresses on APB)
    localparam logic [11:0] PORT_DRIVE_REG_OFS     = 12'h000;
    localparam logic [11:0] PORT_DIRECTION_REG_OFS = 12'h004;
    localparam logic [11:0] PORT_INPUT_REG_OFS     = 12'h008;
    localparam logic [11:0] SPECIAL_FUNC_CTRL_OFS  = 12'h00C;
    localparam logic [11:0] SLEEP_CTRL_OFS         = 12'h010;
    // ==========================================
    // Field positions
    localparam int GLOBAL_PULLUP_DISABLE_BIT = 2;
    localparam int SLEEP_CLAMP_BIT           = 0;
    // ==========================================
    // Reset values
    localparam logic [7:0] PORT_DRIVE_RST     = 8'h00;
    localparam logic [7:0] PORT_DIRECTION_RST = 8'h00;
    localparam logic [7:0] SPECIAL_FUNC_RST   = 8'h00;
    localparam logic [7:0] SYNC_RST           = 8'h00;
    // ==========================================
    // Answer for unmapped reads
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : gdio_pkg

/* File: hw/gdio_sync.sv */
// Two-stage pin input synchroniser: high-transparent latch then rising-edge flop
`timescale 1ns/100ps
module gdio_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_synced
);
    logic [WIDTH-1:0] sync_latch;  // Transparent while clock high
    logic [WIDTH-1:0] synced_r;    // Loaded at the next rising edge
    logic [WIDTH-1:0] synced_nxt;  // Next value of the flop

    // ==========================================
    // Latch stage
    // latch then flop
    // Latch holds while clock low, so the flop sees a value settled for half a period
    always_latch begin
        if (!presetn) begin
            sync_latch <= gdio_pkg::SYNC_RST;
        end else if (pclk) begin
            sync_latch <= pin_in;
        end
    end

    // Flop stage reads the latch only
    always_comb begin
        synced_nxt = sync_latch;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            synced_r <= gdio_pkg::SYNC_RST;
        end else begin
            synced_r <= synced_nxt;
        end
    end

    assign pin_synced = synced_r;
endmodule // gdio_sync

/* File: hw/gdio_port.sv */
// Eight-pin general digital I/O port with APB registers and alternate-function overrides
// ==========================================
`timescale 1ns/100ps
module gdio_port #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] pin_o,
    output logic      [WIDTH-1:0] pin_oe,
    output logic      [WIDTH-1:0] pin_pullup_en,
    input  wire logic [WIDTH-1:0] ext_int_enabled,
    input  wire logic [WIDTH-1:0] pullup_override_en,
    input  wire logic [WIDTH-1:0] pullup_override_val,
    input  wire logic [WIDTH-1:0] direction_override_en,
    input  wire logic [WIDTH-1:0] direction_override_val,
    input  wire logic [WIDTH-1:0] value_override_en,
    input  wire logic [WIDTH-1:0] value_override_val,
    input  wire logic [WIDTH-1:0] input_enable_override_en,
    input  wire logic [WIDTH-1:0] input_enable_override_val,
    output logic      [WIDTH-1:0] pin_digital_in,
    output logic                  global_pullup_disable
);
    // ==========================================
    // Register state
    logic [WIDTH-1:0] port_drive_reg_r;      // Drive level or pull-up request per pin
    logic [WIDTH-1:0] port_drive_reg_nxt;
    logic [WIDTH-1:0] port_direction_reg_r;  // One means output
    logic [WIDTH-1:0] port_direction_reg_nxt;
    logic [7:0]       special_func_ctrl_r;   // Holds the global pull-up disable
    logic [7:0]       special_func_ctrl_nxt;
    logic             sleep_clamp_r;         // Deep sleep indication from software side
    logic             sleep_clamp_nxt;
    logic [31:0]      prdata_r;              // Registered read data
    logic [31:0]      prdata_nxt;
    logic             pslverr_r;             // Registered error answer
    logic             pslverr_nxt;
    logic             map_hit;               // Address decodes to a register
    logic [WIDTH-1:0] port_input_reg;        // Synchronised pin levels
    logic [WIDTH-1:0] input_enable;          // Per-pin digital input enable

    // ==========================================
    // Address decode
    always_comb begin
        unique case (paddr)
            gdio_pkg::PORT_DRIVE_REG_OFS,
            gdio_pkg::PORT_DIRECTION_REG_OFS,
            gdio_pkg::PORT_INPUT_REG_OFS,
            gdio_pkg::SPECIAL_FUNC_CTRL_OFS,
            gdio_pkg::SLEEP_CTRL_OFS: map_hit = 1'b1;
            default:                  map_hit = 1'b0;
        endcase
    end

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;

    // ==========================================
    // Register next values
    always_comb begin
        port_drive_reg_nxt     = port_drive_reg_r;
        port_direction_reg_nxt = port_direction_reg_r;
        special_func_ctrl_nxt  = special_func_ctrl_r;
        sleep_clamp_nxt        = sleep_clamp_r;
        prdata_nxt             = prdata_r;
        pslverr_nxt            = 1'b0;
        if (psel && !penable) begin
            // Setup phase: prepare answer so it is valid in the access cycle
            pslverr_nxt = ~map_hit;
            prdata_nxt  = gdio_pkg::UNMAPPED_READ;
            if (!pwrite) begin
                unique case (paddr)
                    gdio_pkg::PORT_DRIVE_REG_OFS:
                        prdata_nxt = {{(32-WIDTH){1'b0}}, port_drive_reg_r};
                    gdio_pkg::PORT_DIRECTION_REG_OFS:
                        prdata_nxt = {{(32-WIDTH){1'b0}}, port_direction_reg_r};
                    gdio_pkg::PORT_INPUT_REG_OFS:
                        prdata_nxt = {{(32-WIDTH){1'b0}}, port_input_reg};
                    gdio_pkg::SPECIAL_FUNC_CTRL_OFS:
                        prdata_nxt = {24'h000000, special_func_ctrl_r};
                    gdio_pkg::SLEEP_CTRL_OFS:
                        prdata_nxt = {31'h00000000, sleep_clamp_r};
                    default:
                        prdata_nxt = gdio_pkg::UNMAPPED_READ;
                endcase
            end
        end else if (psel && penable && pwrite) begin
            // Access phase of a write: the only edge where a write lands
            unique case (paddr)
                gdio_pkg::PORT_DRIVE_REG_OFS:
                    port_drive_reg_nxt = pwdata[WIDTH-1:0];
                gdio_pkg::PORT_DIRECTION_REG_OFS:
                    port_direction_reg_nxt = pwdata[WIDTH-1:0];
                gdio_pkg::SPECIAL_FUNC_CTRL_OFS:
                    special_func_ctrl_nxt = pwdata[7:0];
                gdio_pkg::SLEEP_CTRL_OFS:
                    sleep_clamp_nxt = pwdata[gdio_pkg::SLEEP_CLAMP_BIT];
                // Input register is read-only; writes ignored
                default: ;
            endcase
        end
    end

    // Register update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_drive_reg_r     <= gdio_pkg::PORT_DRIVE_RST;
            port_direction_reg_r <= gdio_pkg::PORT_DIRECTION_RST;
            special_func_ctrl_r  <= gdio_pkg::SPECIAL_FUNC_RST;
            sleep_clamp_r        <= 1'b0;
            prdata_r             <= 32'h0000_0000;
            pslverr_r            <= 1'b0;
        end else begin
            port_drive_reg_r     <= port_drive_reg_nxt;
            port_direction_reg_r <= port_direction_reg_nxt;
            special_func_ctrl_r  <= special_func_ctrl_nxt;
            sleep_clamp_r        <= sleep_clamp_nxt;
            prdata_r             <= prdata_nxt;
            pslverr_r            <= pslverr_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pslverr = pslverr_r & psel & penable;
    assign global_pullup_disable = special_func_ctrl_r[gdio_pkg::GLOBAL_PULLUP_DISABLE_BIT];

    // ==========================================
    // Per-pin pad control
    // Pad controls are combinational from reset-cleared flops, so pins without a direction
    // override tri-state the instant reset asserts, with no clock needed.
    // relies on software stepping
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            assign pin_oe[g] = direction_override_en[g] ? direction_override_val[g]
                                                        : port_direction_reg_r[g];
            assign pin_o[g] = value_override_en[g] ? value_override_val[g]
                                                   : port_drive_reg_r[g];
            assign pin_pullup_en[g] = pullup_override_en[g] ? pullup_override_val[g]
                : (~port_direction_reg_r[g] & port_drive_reg_r[g] & ~global_pullup_disable);
            assign input_enable[g] = input_enable_override_en[g]
                ? input_enable_override_val[g]
                : (~sleep_clamp_r | ext_int_enabled[g]);
            // clamp forces low, release may edge
            assign pin_digital_in[g] = pin_i[g] & input_enable[g];
        end
    endgenerate

    // ==========================================
    // Input synchroniser
    // driven pin loops back in one period
    gdio_sync #(
        .WIDTH (WIDTH)
    ) u_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_in     (pin_digital_in),
        .pin_synced (port_input_reg)
    );
endmodule // gdio_port

/* File: test/gdio_checker.sv */
// Port-level assertions for the I/O port
`timescale 1ns/100ps
module gdio_checker #(
    parameter int WIDTH = 8
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic [WIDTH-1:0] pin_o,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic [WIDTH-1:0] pin_pullup_en,
    input wire logic [WIDTH-1:0] pullup_override_en,
    input wire logic [WIDTH-1:0] pullup_override_val,
    input wire logic [WIDTH-1:0] direction_override_en,
    input wire logic [WIDTH-1:0] direction_override_val,
    input wire logic [WIDTH-1:0] value_override_en,
    input wire logic [WIDTH-1:0] value_override_val,
    input wire logic [WIDTH-1:0] input_enable_override_en,
    input wire logic [WIDTH-1:0] input_enable_override_val,
    input wire logic [WIDTH-1:0] pin_digital_in,
    input wire logic             global_pullup_disable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // Bus steps
    sequence s_access; psel && penable; endsequence
    sequence s_pud_wr; s_access ##0 pwrite && paddr == gdio_pkg::SPECIAL_FUNC_CTRL_OFS; endsequence
    // ==========================================
    // Checks
    a_ready_zero_wait: assert property (s_access |-> pready)
        else $error("pready low in access");
    a_slverr_map: assert property (s_access ##0 paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h010))
        else $error("pslverr wrong for address");
    a_pud_write: assert property (s_pud_wr |=> global_pullup_disable == $past(pwdata[2]))
        else $error("pullup disable not updated");
    a_reset_float: assert property (!$past(presetn) |-> ((pin_oe & ~direction_override_en) |
        (pin_pullup_en & ~pullup_override_en)) == '0)
        else $error("pin active after reset");
    a_dir_override: assert property (((pin_oe ^ direction_override_val) & direction_override_en) == '0)
        else $error("direction override ignored");
    a_pu_override: assert property (((pin_pullup_en ^ pullup_override_val) & pullup_override_en) == '0)
        else $error("pullup override ignored");
    a_val_override: assert property (((pin_o ^ value_override_val) & value_override_en & pin_oe) == '0)
        else $error("value override ignored");
    a_ie_override: assert property (((pin_digital_in ^ (pin_i & input_enable_override_val)) &
        input_enable_override_en) == '0)
        else $error("input enable override ignored");
    a_pud_all: assert property (global_pullup_disable |-> (pin_pullup_en & ~pullup_override_en) == '0)
        else $error("pullup on while disabled");
    a_no_pu_out: assert property ((pin_pullup_en & pin_oe & ~pullup_override_en & ~direction_override_en) == '0)
        else $error("pullup on an output");
endmodule // gdio_checker

/* File: test/gdio_pads.sv */
// Board model resolving the level on each pad
`timescale 1ns/100ps
module gdio_pads (
    input  wire logic       pclk,
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup_en,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pad
);
    logic [7:0] float_q = 8'h5A; // Floating pins wander, never a steady guess
    always @(posedge pclk) float_q <= ~float_q;
    // driver wins, then board, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pad[i] = pin_o[i];
            else if (ext_en[i]) pad[i] = ext_val[i];
            else if (pin_pullup_en[i]) pad[i] = 1'b1;
            else pad[i] = float_q[i];
        end
    end
endmodule // gdio_pads

/* File: test/tb_top.sv */
// Self-checking bench for the I/O port
`timescale 1ns/100ps
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, global_pullup_disable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  pin_i, pin_o, pin_oe, pin_pullup_en, ext_int_enabled, pin_digital_in, ext_en, ext_val;
    logic [7:0]  pullup_override_en, pullup_override_val, direction_override_en, direction_override_val;
    logic [7:0]  value_override_en, value_override_val, input_enable_override_en, input_enable_override_val;
    logic        er;
    int          errors, check_count, cyc;
    gdio_port dut_u (.*);
    gdio_pads pads_u (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
        .ext_en(ext_en), .ext_val(ext_val), .pad(pin_i));
    always #50 pclk = ~pclk;
    // Hang guard: far above the run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            final_report();
        end
    end
    task automatic final_report;
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            errors++;
        end
    endtask
    // One APB transfer; waits for pready, no fixed latency assumed
    // A wait that never ends is cut off by the hang guard above
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        {ext_int_enabled, ext_en, ext_val, pullup_override_en, pullup_override_val} = '0;
        {direction_override_en, direction_override_val, value_override_en, value_override_val} = '0;
        {input_enable_override_en, input_enable_override_val} = '0;
        // Board holds every pad low so the input register reads a known zero after reset
        ext_en = 8'hFF;
        repeat (5) @(posedge pclk);
        chk("oe_rst", 32'h0, pin_oe);
        chk("pu_rst", 32'h0, pin_pullup_en);
        presetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            apb(0, a[11:0], 8'h00);
            chk("reg_rst", 32'h0, rd);
        end
        ext_en <= 8'hF0; ext_val <= 8'hA0;
        for (int p = 0; p < 2; p++) begin
            // Drive before direction: every pin crosses a legal middle state
            apb(1, gdio_pkg::PORT_DRIVE_REG_OFS, 8'h33);
            apb(1, gdio_pkg::PORT_DIRECTION_REG_OFS, 8'h0F);
            apb(1, gdio_pkg::SPECIAL_FUNC_CTRL_OFS, p ? 8'h04 : 8'h00);
            @(posedge pclk);
            chk("oe", 32'h0F, pin_oe);
            chk("out", 32'h03, pin_o & pin_oe);
            chk("pu", p ? 32'h0 : 32'h30, pin_pullup_en);
            chk("pud", p, global_pullup_disable);
        end
        apb(0, gdio_pkg::PORT_DIRECTION_REG_OFS, 8'h00);
        chk("dir_rd", 32'h0F, rd);
        apb(1, gdio_pkg::PORT_INPUT_REG_OFS, 8'hFF);
        apb(0, gdio_pkg::PORT_INPUT_REG_OFS, 8'h00);
        chk("in_rd", 32'hA3, rd);
        apb(0, 12'h020, 8'h00);
        chk("unmap_err", 32'h1, {31'h0, er});
        chk("unmap_rd", 32'h0, rd);
        apb(1, gdio_pkg::SLEEP_CTRL_OFS, 8'h01);
        ext_int_enabled <= 8'h01; input_enable_override_en <= 8'h02; input_enable_override_val <= 8'h02;
        repeat (3) @(posedge pclk);
        chk("clamp", 32'h03, pin_digital_in);
        apb(0, gdio_pkg::PORT_INPUT_REG_OFS, 8'h00);
        chk("clamp_rd", 32'h03, rd);
        apb(1, gdio_pkg::SLEEP_CTRL_OFS, 8'h00);
        direction_override_en <= 8'h80; direction_override_val <= 8'h80; value_override_en <= 8'h80;
        pullup_override_en <= 8'h40; pullup_override_val <= 8'h40;
        repeat (2) @(posedge pclk);
        chk("wake", 32'h23, pin_digital_in);
        chk("oe_ovr", 32'h8F, pin_oe);
        chk("pu_ovr", 32'h40, pin_pullup_en);
        final_report();
    end
endmodule // tb_top
bind gdio_port gdio_checker #(.WIDTH(WIDTH)) chk_u (.*);
